// ===== inc/pic_pkg.sv
// constants and types shared by the priority interrupt controller
package pic_pkg;
   localparam logic [11:0] REQ_A_ADDR    = 12'hfc0;
   localparam logic [11:0] PRIO_HI_A_ADDR = 12'hfc1;
   localparam logic [11:0] PRIO_LO_A_ADDR = 12'hfc2;
   localparam logic [11:0] REQ_B_ADDR    = 12'hfc3;
   localparam logic [11:0] PRIO_HI_B_ADDR = 12'hfc4;
   localparam logic [11:0] PRIO_LO_B_ADDR = 12'hfc5;
   localparam logic [11:0] CTRL_ADDR     = 12'hfcf;
   localparam int          CTRL_GLOBAL_IRQ_ENABLE_BIT = 7;
   localparam int          NUM_SRC       = 16;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   // vector address of source index 0 (timer 2), step 2 per source
   localparam logic [15:0] VEC_BASE      = 16'h0008;
   localparam logic [15:0] VEC_WDT       = 16'h0004;
   localparam logic [15:0] VEC_PRI_OSC   = 16'h003a;
   localparam logic [15:0] VEC_WDT_OSC   = 16'h003c;
   localparam logic [15:0] VEC_ILLEGAL   = 16'h0006;
   localparam logic [1:0]  LVL_OFF       = 2'h0;
   localparam logic [1:0]  LVL_1         = 2'h1;
   localparam logic [1:0]  LVL_2         = 2'h2;
   localparam logic [1:0]  LVL_3         = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_PRESENT} pic_state_t;
endpackage

// ===== verilog/pic_arbiter.sv
// three-level fixed-order arbiter for the sixteen ranked sources
`timescale 1ns/1ps
module pic_arbiter
   import pic_pkg::*;
(
   input  wire logic [NUM_SRC-1:0] pending,
   input  wire logic [NUM_SRC-1:0] prioHi,
   input  wire logic [NUM_SRC-1:0] prioLo,
   output logic                    found,
   output logic [3:0]              winner
);
   logic [NUM_SRC-1:0] atLevel [1:3];

   // per source level match
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++)
      begin : g_lvl
         assign atLevel[1][g] = pending[g] & ({prioHi[g], prioLo[g]} == LVL_1); // R18
         assign atLevel[2][g] = pending[g] & ({prioHi[g], prioLo[g]} == LVL_2); // R18
         assign atLevel[3][g] = pending[g] & ({prioHi[g], prioLo[g]} == LVL_3); // R18
      end
   endgenerate

   // highest level first, lowest index (vector order) first within a level
   always_comb
   begin
      found  = 1'b0;
      winner = 4'h0;
      for (int l = 3; l >= 1; l--) // R3
      begin
         for (int i = NUM_SRC - 1; i >= 0; i--) // R4 R5
         begin
            if (!found && atLevel[l][i])
            begin
               winner = 4'(i);
            end
         end
         if (atLevel[l] != '0)
         begin
            found = 1'b1;
         end
      end
   end
endmodule // pic_arbiter

// ===== verilog/pic_controller.sv
// priority interrupt controller: request latches, enables, arbitration, core handshake
`timescale 1ns/1ps
// How it works
// R1: global enable set by enable or return instruction, or software writing one.
// R2: global enable cleared by disable, acknowledge, software zero, reset, traps.
// R3: level 3 beats level 2, level 2 beats level 1.
// R4: within a level, fixed order following the vector table.
// R5: order timer 2 down to converter, then port A7 down to A0.
// R6: reset, watchdog, oscillator fails, illegal trap always highest priority.
// R7: sources pulse one clock; each pulse is latched into its request bit.
// R8: acknowledge clears the served source's request bit until next pulse.
// R9: software writing zero to a request bit clears it.
// R10: software writing one creates a request, cleared on acknowledge.
// R11: software should use atomic read-modify-write on request registers.
// R12: watchdog and oscillator fails bypass request, enable, priority registers.
// R13: a source pulse sets its request bit regardless of global enable.
// R14: with global enable set, the winner goes to the core as vectored interrupt.
// R15: with global enable clear, requests are only recorded for polling.
// R16: first request register bit map at fc0.
// R17: second request register bit map at fc3.
// R18: enable bit pair: 00 off, 01 level 1, 10 level 2, 11 level 3.
// R19: vector shown with request strobe; acknowledge pulse clears bit and enable.
module pic_controller
   import pic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  requestsA,
   input  wire logic [7:0]  requestsB,
   input  wire logic        watchdogIrq,
   input  wire logic        primaryOscFail,
   input  wire logic        watchdogOscFail,
   input  wire logic        illegalTrap,
   input  wire logic        trapInstruction,
   input  wire logic        enableIrqInstruction,
   input  wire logic        disableIrqInstruction,
   input  wire logic        irqReturnInstruction,
   input  wire logic [11:0] regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   output logic             irqRequest,
   output logic      [15:0] irqVector,
   input  wire logic        irqAck
);
   logic [7:0]  requestFlagsA_r, requestFlagsA_nxt;
   logic [7:0]  requestFlagsB_r, requestFlagsB_nxt;
   logic [7:0]  prioHighBitsA_r, prioHighBitsA_nxt;
   logic [7:0]  prioLowBitsA_r,  prioLowBitsA_nxt;
   logic [7:0]  prioHighBitsB_r, prioHighBitsB_nxt;
   logic [7:0]  prioLowBitsB_r,  prioLowBitsB_nxt;
   logic        globalIrqEnable_r, globalIrqEnable_nxt;
   logic [15:0] irqVector_r, irqVector_nxt;
   logic [3:0]  srcIdx_r, srcIdx_nxt;
   logic        srcRanked_r, srcRanked_nxt;
   logic [7:0]  regRdata_r, regRdata_nxt;
   pic_state_t  state_r, state_nxt;
   logic [15:0] pendAll;
   logic [15:0] prioHiAll;
   logic [15:0] prioLoAll;
   logic [15:0] ackMask;
   logic        found;
   logic [3:0]  winner;
   logic        trapEvent;
   logic        ackPulse;

   // index 0 is timer 2 (vector order), so bit order is reversed per register
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pendAll[i]       = requestFlagsA_r[7 - i]; // R5 R16
         pendAll[8 + i]   = requestFlagsB_r[7 - i]; // R5 R17
         prioHiAll[i]     = prioHighBitsA_r[7 - i]; // R18
         prioHiAll[8 + i] = prioHighBitsB_r[7 - i]; // R18
         prioLoAll[i]     = prioLowBitsA_r[7 - i]; // R18
         prioLoAll[8 + i] = prioLowBitsB_r[7 - i]; // R18
      end
   end

   pic_arbiter u_arb (
      .pending (pendAll),
      .prioHi  (prioHiAll),
      .prioLo  (prioLoAll),
      .found   (found),
      .winner  (winner)
   );

   assign trapEvent = primaryOscFail | watchdogOscFail | illegalTrap;
   assign ackPulse  = irqAck && state_r == ST_PRESENT; // R19

   // acknowledged ranked source clears only its own bit
   always_comb
   begin
      ackMask = 16'h0000;
      if (ackPulse && srcRanked_r)
      begin
         ackMask[srcIdx_r] = 1'b1; // R8
      end
   end

   // request, enable and control register next values
   always_comb
   begin
      requestFlagsA_nxt = requestFlagsA_r;
      requestFlagsB_nxt = requestFlagsB_r;
      prioHighBitsA_nxt = prioHighBitsA_r;
      prioLowBitsA_nxt  = prioLowBitsA_r;
      prioHighBitsB_nxt = prioHighBitsB_r;
      prioLowBitsB_nxt  = prioLowBitsB_r;
      globalIrqEnable_nxt = globalIrqEnable_r;
      if (regWrite)
      begin
         case (regAddr)
            REQ_A_ADDR:     requestFlagsA_nxt = regWdata; // R9 R10
            REQ_B_ADDR:     requestFlagsB_nxt = regWdata; // R9 R10
            PRIO_HI_A_ADDR: prioHighBitsA_nxt = regWdata;
            PRIO_LO_A_ADDR: prioLowBitsA_nxt  = regWdata;
            PRIO_HI_B_ADDR: prioHighBitsB_nxt = regWdata;
            PRIO_LO_B_ADDR: prioLowBitsB_nxt  = regWdata;
            CTRL_ADDR:      globalIrqEnable_nxt = regWdata[CTRL_GLOBAL_IRQ_ENABLE_BIT]; // R1 R2
            default:        ;
         endcase
      end
      for (int i = 0; i < 8; i++)
      begin
         if (ackMask[i])
         begin
            requestFlagsA_nxt[7 - i] = 1'b0; // R8 R10
         end
         if (ackMask[8 + i])
         begin
            requestFlagsB_nxt[7 - i] = 1'b0; // R8 R10
         end
      end
      // a fresh pulse wins over any clear in the same cycle
      requestFlagsA_nxt = requestFlagsA_nxt | requestsA; // R7 R13
      requestFlagsB_nxt = requestFlagsB_nxt | requestsB; // R7 R13
      if (enableIrqInstruction || irqReturnInstruction)
      begin
         globalIrqEnable_nxt = 1'b1; // R1
      end
      if (disableIrqInstruction || ackPulse || trapInstruction || trapEvent)
      begin
         globalIrqEnable_nxt = 1'b0; // R2
      end
   end

   // core handshake: pick winner, hold vector until acknowledge
   always_comb
   begin
      state_nxt     = state_r;
      irqVector_nxt = irqVector_r;
      srcIdx_nxt    = srcIdx_r;
      srcRanked_nxt = srcRanked_r;
      case (state_r)
         ST_IDLE:
         begin
            // fixed traps and watchdog need no enable and no register
            if (primaryOscFail || watchdogOscFail || illegalTrap || watchdogIrq) // R6 R12
            begin
               state_nxt     = ST_PRESENT;
               srcRanked_nxt = 1'b0;
               irqVector_nxt = primaryOscFail  ? VEC_PRI_OSC :
                               watchdogOscFail ? VEC_WDT_OSC :
                               illegalTrap     ? VEC_ILLEGAL : VEC_WDT;
            end
            else if (globalIrqEnable_r && found) // R14 R15
            begin
               state_nxt     = ST_PRESENT;
               srcRanked_nxt = 1'b1;
               srcIdx_nxt    = winner;
               irqVector_nxt = VEC_BASE + {11'h000, winner, 1'b0};
            end
         end
         ST_PRESENT:
         begin
            if (irqAck)
            begin
               state_nxt = ST_IDLE; // R19
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // read data for the polled path
   always_comb
   begin
      regRdata_nxt = 8'h00;
      if (regRead)
      begin
         case (regAddr)
            REQ_A_ADDR:     regRdata_nxt = requestFlagsA_r; // R15
            REQ_B_ADDR:     regRdata_nxt = requestFlagsB_r; // R15
            PRIO_HI_A_ADDR: regRdata_nxt = prioHighBitsA_r;
            PRIO_LO_A_ADDR: regRdata_nxt = prioLowBitsA_r;
            PRIO_HI_B_ADDR: regRdata_nxt = prioHighBitsB_r;
            PRIO_LO_B_ADDR: regRdata_nxt = prioLowBitsB_r;
            CTRL_ADDR:      regRdata_nxt = {globalIrqEnable_r, 7'h00};
            default:        regRdata_nxt = 8'h00;
         endcase
      end
   end

   // registers, all zero at reset
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         requestFlagsA_r   <= REG_RESET;
         requestFlagsB_r   <= REG_RESET;
         prioHighBitsA_r   <= REG_RESET;
         prioLowBitsA_r    <= REG_RESET;
         prioHighBitsB_r   <= REG_RESET;
         prioLowBitsB_r    <= REG_RESET;
         globalIrqEnable_r <= 1'b0; // R2
         irqVector_r       <= 16'h0000;
         srcIdx_r          <= 4'h0;
         srcRanked_r       <= 1'b0;
         regRdata_r        <= 8'h00;
         state_r           <= ST_IDLE;
      end
      else
      begin
         requestFlagsA_r   <= requestFlagsA_nxt;
         requestFlagsB_r   <= requestFlagsB_nxt;
         prioHighBitsA_r   <= prioHighBitsA_nxt;
         prioLowBitsA_r    <= prioLowBitsA_nxt;
         prioHighBitsB_r   <= prioHighBitsB_nxt;
         prioLowBitsB_r    <= prioLowBitsB_nxt;
         globalIrqEnable_r <= globalIrqEnable_nxt;
         irqVector_r       <= irqVector_nxt;
         srcIdx_r          <= srcIdx_nxt;
         srcRanked_r       <= srcRanked_nxt;
         regRdata_r        <= regRdata_nxt;
         state_r           <= state_nxt;
      end
   end

   assign irqRequest = state_r == ST_PRESENT;
   assign irqVector  = irqVector_r;
   assign regRdata   = regRdata_r;

   // checks
   a_pulse_sets_bit: assert property (@(posedge clk) disable iff (reset) // R7 R13
      requestsA[7] |=> requestFlagsA_r[7]) else $error("request pulse not latched");
   a_ack_clears_en: assert property (@(posedge clk) disable iff (reset) // R2
      ackPulse |=> !globalIrqEnable_r) else $error("enable not cleared on ack");
   a_ei_sets_en: assert property (@(posedge clk) disable iff (reset) // R1
      enableIrqInstruction && !disableIrqInstruction && !trapInstruction && !trapEvent && !ackPulse
      |=> globalIrqEnable_r) else $error("enable not set");
   a_no_irq_disabled: assert property (@(posedge clk) disable iff (reset) // R14 R15
      $rose(irqRequest) && srcRanked_r |-> $past(globalIrqEnable_r)) else $error("irq while disabled");
   a_ack_clears_src: assert property (@(posedge clk) disable iff (reset) // R8
      ackPulse && srcRanked_r && srcIdx_r == 4'h0 && !requestsA[7] |=> !requestFlagsA_r[7])
      else $error("acked bit not cleared");
   a_vector_holds: assert property (@(posedge clk) disable iff (reset) // R19
      irqRequest && !irqAck |=> irqRequest && $stable(irqVector)) else $error("vector moved");
   a_trap_first: assert property (@(posedge clk) disable iff (reset) // R6 R12
      state_r == ST_IDLE && primaryOscFail |=> irqVector == VEC_PRI_OSC) else $error("trap not first");
   a_sw_zero_clears: assert property (@(posedge clk) disable iff (reset) // R9
      regWrite && regAddr == REQ_B_ADDR && regWdata == 8'h00 && requestsB == 8'h00
      |=> requestFlagsB_r == 8'h00) else $error("sw clear failed");
   // a pending level 3 source must win and be the one presented
   a_level_order: assert property (@(posedge clk) disable iff (reset) // R3
      state_r == ST_IDLE && globalIrqEnable_r && !watchdogIrq && !trapEvent
      && (pendAll & prioHiAll & prioLoAll) != 16'h0000
      |-> ({prioHiAll[winner], prioLoAll[winner]} == LVL_3)
      ##1 (srcRanked_r && srcIdx_r == $past(winner))) else $error("level order");
endmodule // pic_controller

// ===== tb/pic_core_model.sv
// behavioural processor core that takes presented vectors and acknowledges them
`timescale 1ns/1ps
module pic_core_model
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        irqRequest,
   input  wire logic [15:0] irqVector,
   input  wire logic [3:0]  ackDelay,
   output logic             irqAck,
   output logic      [15:0] lastVector,
   output int               ackCount
);
   logic [3:0] waitCnt;

   initial irqAck = 1'b0;

   // one-cycle ack after ackDelay cycles of a standing request
   always @(negedge clk)
   begin
      irqAck <= 1'b0;
      if (reset || !irqRequest || irqAck)
         waitCnt <= 4'h0;
      else if (waitCnt == ackDelay)
         irqAck <= 1'b1;
      else
         waitCnt <= waitCnt + 4'h1;
   end

   // vector taken at the edge that sees the ack
   always @(posedge clk)
   begin
      if (reset)
         ackCount <= 0;
      else if (irqAck && irqRequest)
      begin
         lastVector <= irqVector;
         ackCount   <= ackCount + 1;
      end
   end
endmodule // pic_core_model

// ===== tb/pic_controller_tb_top.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module pic_controller_tb_top
   import pic_pkg::*;
;
   logic        clk, reset, regWrite, regRead, irqRequest, irqAck;
   logic        watchdogIrq, primaryOscFail, watchdogOscFail, illegalTrap;
   logic        trapInstruction, enableIrqInstruction, disableIrqInstruction, irqReturnInstruction;
   logic [7:0]  requestsA, requestsB, regWdata, regRdata;
   logic [11:0] regAddr;
   logic [15:0] irqVector, lastVector;
   logic [3:0]  ackDelay;
   int          ackCount, n_fail, checked;
   int          order [5] = '{1, 7, 0, 8, 15};

   pic_controller i_pic_controller (.clk(clk), .reset(reset), .requestsA(requestsA), .requestsB(requestsB),
      .watchdogIrq(watchdogIrq), .primaryOscFail(primaryOscFail), .watchdogOscFail(watchdogOscFail),
      .illegalTrap(illegalTrap), .trapInstruction(trapInstruction), .enableIrqInstruction(enableIrqInstruction),
      .disableIrqInstruction(disableIrqInstruction), .irqReturnInstruction(irqReturnInstruction),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .irqRequest(irqRequest), .irqVector(irqVector), .irqAck(irqAck));
   pic_core_model i_pic_core_model (.clk(clk), .reset(reset), .irqRequest(irqRequest), .irqVector(irqVector),
      .ackDelay(ackDelay), .irqAck(irqAck), .lastVector(lastVector), .ackCount(ackCount));

   // free-running clock
   always #5 clk = ~clk;

   task automatic close_out;
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // single atomic register write, strobe one cycle
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      {regAddr, regWdata, regWrite} = {a, d, 1'b1};
      @(negedge clk);
      regWrite = 1'b0;
   endtask

   // register read, data compared the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk);
      {regAddr, regRead} = {a, 1'b1};
      @(negedge clk);
      regRead = 1'b0;
      `CHK(regRdata, e)
   endtask

   // one-cycle source pulses
   task automatic pulse(input logic [7:0] a, input logic [7:0] b);
      @(negedge clk);
      {requestsA, requestsB} = {a, b};
      @(negedge clk);
      {requestsA, requestsB} = 16'h0000;
   endtask

   // one-cycle core instruction pulses: trap, enable, disable, return
   task automatic ins(input logic [3:0] m);
      @(negedge clk);
      {trapInstruction, enableIrqInstruction, disableIrqInstruction, irqReturnInstruction} = m;
      @(negedge clk);
      {trapInstruction, enableIrqInstruction, disableIrqInstruction, irqReturnInstruction} = 4'h0;
   endtask

   // no vector may be presented for a while
   task automatic quiet;
      repeat (6)
      begin
         @(negedge clk);
         `CHK(irqRequest, 1'b0)
      end
   endtask

   // bounded wait for the next ack, then compare the vector taken
   task automatic wait_ack(input logic [15:0] v);
      int n0;
      n0 = ackCount;
      repeat (60)
         if (ackCount == n0)
            @(negedge clk);
      `CHK(ackCount, n0 + 1)
      `CHK(lastVector, v)
   endtask

   // hang guard
   initial
   begin
      #200000;
      n_fail++;
      close_out();
   end

   // main sequence
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      {regWrite, regRead, regAddr, regWdata, requestsA, requestsB, ackDelay} = 42'h0;
      {watchdogIrq, primaryOscFail, watchdogOscFail, illegalTrap} = 4'h0;
      {trapInstruction, enableIrqInstruction, disableIrqInstruction, irqReturnInstruction} = 4'h0;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      rd(REQ_A_ADDR, REG_RESET);
      rd(REQ_B_ADDR, REG_RESET);
      rd(CTRL_ADDR, 8'h00);
      wr(12'h100, 8'h55);
      rd(12'h100, 8'h00);
      // polling: enable clear, pulses only recorded
      wr(PRIO_LO_A_ADDR, 8'hff);
      pulse(8'h81, 8'h01);
      quiet();
      rd(REQ_A_ADDR, 8'h81);
      rd(REQ_B_ADDR, 8'h01);
      wr(REQ_A_ADDR, 8'h00);
      rd(REQ_A_ADDR, 8'h00);
      wr(REQ_B_ADDR, 8'h00);
      // pair 00 keeps a pending source silent under global enable
      wr(PRIO_LO_A_ADDR, 8'h00);
      wr(REQ_A_ADDR, 8'h40);
      wr(CTRL_ADDR, 8'h80);
      quiet();
      rd(CTRL_ADDR, 8'h80);
      foreach (order[i])
      begin
         wr(CTRL_ADDR, 8'h80);
         ins((i % 2) ? 4'h8 : 4'h2);
         rd(CTRL_ADDR, 8'h00);
      end
      // a6 level 3, a0 level 2, a7 b7 b0 level 1
      wr(PRIO_HI_A_ADDR, 8'h41);
      wr(PRIO_LO_A_ADDR, 8'hc0);
      wr(PRIO_LO_B_ADDR, 8'h81);
      wr(REQ_A_ADDR, 8'hc1);
      wr(REQ_B_ADDR, 8'h81);
      foreach (order[i])
      begin
         ackDelay = 4'(3 * (i % 2));
         case (i % 3)
            0: wr(CTRL_ADDR, 8'h80);
            1: ins(4'h4);
            default: ins(4'h1);
         endcase
         wait_ack(VEC_BASE + 16'(2 * order[i]));
         rd(CTRL_ADDR, 8'h00);
      end
      rd(REQ_A_ADDR, 8'h00);
      rd(REQ_B_ADDR, 8'h00);
      // fixed traps win with enable clear and a level 3 source pending
      wr(REQ_A_ADDR, 8'h40);
      foreach (order[i])
         if (i < 4)
         begin
            {primaryOscFail, watchdogOscFail, illegalTrap, watchdogIrq} = 4'h8 >> i;
            wait_ack(i == 0 ? VEC_PRI_OSC : i == 1 ? VEC_WDT_OSC : i == 2 ? VEC_ILLEGAL : VEC_WDT);
            {primaryOscFail, watchdogOscFail, illegalTrap, watchdogIrq} = 4'h0;
         end
      rd(REQ_A_ADDR, 8'h40);
      close_out();
   end
endmodule // pic_controller_tb_top
